// file: rtl/irt_pkg.sv
// package for the infrared timer control register block
// assumes a byte-wide register port with six registers at offsets 0..5
package irt_pkg;
    localparam logic [1:0] ADDR_CARRIER_CTRL = 2'h0;
    localparam logic [1:0] ADDR_COMMON_CTRL  = 2'h1;
    localparam logic [1:0] ADDR_WIDE_CTRL    = 2'h2;
    localparam logic [1:0] ADDR_PAIR_CTRL    = 2'h3;
    localparam logic [3:0] ADDR_IRQ_STATUS   = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MASK     = 4'h5;
    // carrier control bit positions
    localparam int CC_PIN    = 7;
    localparam int CC_TOIE   = 6;
    localparam int CC_CAPIE  = 5;
    localparam int CC_PRE_HI = 4;
    localparam int CC_PRE_LO = 3;
    localparam int CC_TOF    = 2;
    localparam int CC_SINGLE = 1;
    localparam int CC_EN     = 0;
    // common control bit positions
    localparam int CM_FALL   = 7;
    localparam int CM_RISE   = 6;
    localparam int CM_F1_HI  = 5;
    localparam int CM_F1_LO  = 4;
    localparam int CM_F2_HI  = 3;
    localparam int CM_F2_LO  = 2;
    localparam int CM_PINSEL = 1;
    localparam int CM_MODE   = 0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_IRQ  = 3'h0;
    localparam int FILT_SHORT = 4;
    localparam int FILT_LONG  = 8;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } irt_bus_s;
    typedef enum logic [1:0] {
        IRT_EDGE_FALL = 2'h0,
        IRT_EDGE_RISE = 2'h1,
        IRT_EDGE_BOTH = 2'h2
    } irt_edge_e;
endpackage : irt_pkg

// file: rtl/irt_regs.sv
// control and status registers of the carrier and wide infrared timers
// assumes counters outside; strobes are one-cycle pulses in clk_i domain
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module irt_regs (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        stop_recovery_i,
    // register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    // timer side
    input  wire logic        carrier_timeout_i,
    input  wire logic        carrier_capture_i,
    input  wire logic        carrier_timer_output_i,
    input  wire logic        wide_timer_output_i,
    input  wire logic        wide_start_i,
    input  wire logic        sync_enable_i,
    input  wire logic        port_data_34_i,
    input  wire logic        port_data_36_i,
    input  wire logic        primary_demod_input_pin_i,
    input  wire logic        alternate_demod_input_pin_i,
    output logic             carrier_tick_o,
    output logic             carrier_run_o,
    output logic             carrier_single_o,
    output logic             carrier_sync_load_o,
    output logic             ping_pong_o,
    output logic             carrier_output_pin_o,
    output logic             combined_output_pin_o,
    output logic             demod_level_o,
    // interrupt
    output logic             irq_o
);
    logic [7:0] carrier_ctl;
    logic [7:0] common_ctl;
    logic [7:0] wide_ctl;
    logic [7:0] pair_ctl;
    logic       tof;
    logic       fall_flag;
    logic       rise_flag;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [2:0] pre_cnt;
    logic [3:0] filt_cnt;
    logic       demod_raw;
    logic       demod_filt;
    logic       demod_prev;
    logic       fall_evt;
    logic       rise_evt;
    logic       wide_prev;
    logic       wr_cc;
    logic       wr_cm;
    logic       demod_mode;
    logic [1:0] edge_sel;
    logic [1:0] filt_sel;
    logic       combined;
    logic       comb_pre;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_a);
        hit = (a == ref_a);
    endfunction : hit

    assign wr_cc = wr_i && hit(addr_i, {2'h0, irt_pkg::ADDR_CARRIER_CTRL});
    assign wr_cm = wr_i && hit(addr_i, {2'h0, irt_pkg::ADDR_COMMON_CTRL});
    assign demod_mode = common_ctl[irt_pkg::CM_MODE];
    assign edge_sel   = common_ctl[irt_pkg::CM_F2_HI:irt_pkg::CM_F2_LO];
    assign filt_sel   = common_ctl[irt_pkg::CM_F1_HI:irt_pkg::CM_F1_LO];

    // carrier control, interrupt enables and prescale keep value on stop recovery; run enable clears
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            carrier_ctl <= irt_pkg::RST_BYTE;
        end else if (wr_cc) begin
            carrier_ctl <= wdata_i;
        end else if (stop_recovery_i) begin
            carrier_ctl <= carrier_ctl & (8'h1 << irt_pkg::CC_TOIE | 8'h1 << irt_pkg::CC_CAPIE
                           | 8'h1 << irt_pkg::CC_PRE_HI | 8'h1 << irt_pkg::CC_PRE_LO);
        end
    end

    // common control; output logic field survives stop recovery
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            common_ctl <= irt_pkg::RST_BYTE;
        end else if (wr_cm) begin
            common_ctl <= wdata_i;
        end else if (stop_recovery_i) begin
            common_ctl <= common_ctl & (8'h1 << irt_pkg::CM_F2_HI | 8'h1 << irt_pkg::CM_F2_LO);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wide_ctl <= irt_pkg::RST_BYTE;
            pair_ctl <= irt_pkg::RST_BYTE;
        end else if (wr_i && hit(addr_i, {2'h0, irt_pkg::ADDR_WIDE_CTRL})) begin
            wide_ctl <= wdata_i;
        end else if (wr_i && hit(addr_i, {2'h0, irt_pkg::ADDR_PAIR_CTRL})) begin
            pair_ctl <= wdata_i;
        end
    end

    // timeout flag, set wins over clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tof <= 1'b0;
        end else if (carrier_timeout_i) begin
            tof <= 1'b1;
        end else if (wr_cc && wdata_i[irt_pkg::CC_TOF]) begin
            tof <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || !carrier_ctl[irt_pkg::CC_EN]) begin
            pre_cnt <= 3'h0;
        end else begin
            pre_cnt <= pre_cnt + 3'h1;
        end
    end
    always_comb begin
        case (carrier_ctl[irt_pkg::CC_PRE_HI:irt_pkg::CC_PRE_LO])
            2'h0:    carrier_tick_o = carrier_ctl[irt_pkg::CC_EN];
            2'h1:    carrier_tick_o = carrier_ctl[irt_pkg::CC_EN] && (pre_cnt[0] == 1'b1);
            2'h2:    carrier_tick_o = carrier_ctl[irt_pkg::CC_EN] && (pre_cnt[1:0] == 2'h3);
            default: carrier_tick_o = carrier_ctl[irt_pkg::CC_EN] && (pre_cnt == 3'h7);
        endcase
    end
    assign carrier_run_o    = carrier_ctl[irt_pkg::CC_EN];
    assign carrier_single_o = carrier_ctl[irt_pkg::CC_SINGLE];

    assign demod_raw = common_ctl[irt_pkg::CM_PINSEL] ? alternate_demod_input_pin_i
                                                      : primary_demod_input_pin_i;

    // glitch filter: level must hold the selected number of cycles
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            filt_cnt   <= 4'h0;
            demod_filt <= 1'b0;
        end else if (filt_sel == 2'h0 || filt_sel == 2'h3) begin
            filt_cnt   <= 4'h0;
            demod_filt <= demod_raw;
        end else if (demod_raw == demod_filt) begin
            filt_cnt <= 4'h0;
        end else if (filt_cnt == ((filt_sel == 2'h1) ? 4'(irt_pkg::FILT_SHORT - 1)
                                                    : 4'(irt_pkg::FILT_LONG - 1))) begin
            filt_cnt   <= 4'h0;
            demod_filt <= demod_raw;
        end else begin
            filt_cnt <= filt_cnt + 4'h1;
        end
    end
    assign demod_level_o = demod_filt;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            demod_prev <= 1'b0;
            wide_prev  <= 1'b0;
        end else begin
            demod_prev <= demod_filt;
            wide_prev  <= wide_start_i;
        end
    end

    assign fall_evt = demod_mode && demod_prev && !demod_filt
                      && (edge_sel == irt_pkg::IRT_EDGE_FALL || edge_sel == irt_pkg::IRT_EDGE_BOTH);
    assign rise_evt = demod_mode && !demod_prev && demod_filt
                      && (edge_sel == irt_pkg::IRT_EDGE_RISE || edge_sel == irt_pkg::IRT_EDGE_BOTH);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fall_flag <= 1'b0;
            rise_flag <= 1'b0;
        end else begin
            if (fall_evt) begin
                fall_flag <= 1'b1;
            end else if (wr_cm && demod_mode && wdata_i[irt_pkg::CM_FALL]) begin
                fall_flag <= 1'b0;
            end
            if (rise_evt) begin
                rise_flag <= 1'b1;
            end else if (wr_cm && demod_mode && wdata_i[irt_pkg::CM_RISE]) begin
                rise_flag <= 1'b0;
            end
        end
    end

    // reload carrier at wide timer start so first pulse is whole
    assign carrier_sync_load_o = sync_enable_i && wide_start_i && !wide_prev;

    always_comb begin
        case (edge_sel)
            2'h0:    comb_pre = carrier_timer_output_i & wide_timer_output_i;
            2'h1:    comb_pre = carrier_timer_output_i | wide_timer_output_i;
            2'h2:    comb_pre = ~(carrier_timer_output_i | wide_timer_output_i);
            default: comb_pre = ~(carrier_timer_output_i & wide_timer_output_i);
        endcase
        case (filt_sel)
            2'h2:    combined = 1'b0;
            2'h3:    combined = 1'b1;
            default: combined = comb_pre;
        endcase
    end
    assign ping_pong_o = !demod_mode && (filt_sel == 2'h1);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            carrier_output_pin_o  <= 1'b0;
            combined_output_pin_o <= 1'b0;
        end else begin
            carrier_output_pin_o  <= carrier_ctl[irt_pkg::CC_PIN] ? carrier_timer_output_i : port_data_34_i;
            combined_output_pin_o <= (!demod_mode && common_ctl[irt_pkg::CM_PINSEL]) ? combined
                                                                                     : port_data_36_i;
        end
    end

    // sticky interrupt status: timeout, capture, edge
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_status <= irt_pkg::RST_IRQ;
            irq_mask   <= irt_pkg::RST_IRQ;
        end else begin
            irq_status <= {fall_evt | rise_evt, carrier_capture_i, carrier_timeout_i}
                        | (irq_status & ~((wr_i && addr_i == irt_pkg::ADDR_IRQ_STATUS) ? wdata_i[2:0] : 3'h0));
            if (wr_i && addr_i == irt_pkg::ADDR_IRQ_MASK) begin
                irq_mask <= wdata_i[2:0];
            end
        end
    end
    assign irq_o = |(irq_status & irq_mask & {1'b1, carrier_ctl[irt_pkg::CC_CAPIE], carrier_ctl[irt_pkg::CC_TOIE]});

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                {2'h0, irt_pkg::ADDR_CARRIER_CTRL}: rdata_o <= {carrier_ctl[7:3], tof, carrier_ctl[1:0]};
                {2'h0, irt_pkg::ADDR_COMMON_CTRL}:  rdata_o <= demod_mode ? {fall_flag, rise_flag, common_ctl[5:0]}
                                                                          : common_ctl;
                {2'h0, irt_pkg::ADDR_WIDE_CTRL}:    rdata_o <= wide_ctl;
                {2'h0, irt_pkg::ADDR_PAIR_CTRL}:    rdata_o <= pair_ctl;
                irt_pkg::ADDR_IRQ_STATUS:           rdata_o <= {5'h00, irq_status};
                irt_pkg::ADDR_IRQ_MASK:             rdata_o <= {5'h00, irq_mask};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    a_timeout_sets: assert property (@(posedge clk_i) disable iff (srst_i)
        carrier_timeout_i |=> tof) else $error("timeout flag not set");
    a_fall_sets: assert property (@(posedge clk_i) disable iff (srst_i)
        fall_evt |=> fall_flag) else $error("fall flag not set");
    a_rise_sets: assert property (@(posedge clk_i) disable iff (srst_i)
        rise_evt |=> rise_flag) else $error("rise flag not set");
    a_read_keeps: assert property (@(posedge clk_i) disable iff (srst_i)
        (rd_i && !wr_i && tof) |=> tof) else $error("read cleared flag");
    // combined pin follows port when not selected
    a_pin_port: assert property (@(posedge clk_i) disable iff (srst_i)
        (!common_ctl[irt_pkg::CM_PINSEL] && !wr_cm) |=> combined_output_pin_o == $past(port_data_36_i))
        else $error("combined pin not port");
    // undivided prescale ticks every enabled cycle
    a_prescale_one: assert property (@(posedge clk_i) disable iff (srst_i)
        (carrier_run_o && carrier_ctl[4:3] == 2'h0) |-> carrier_tick_o) else $error("no tick");
    a_stopped: assert property (@(posedge clk_i) disable iff (srst_i)
        !carrier_run_o |-> !carrier_tick_o) else $error("tick while stopped");
    a_force_high: assert property (@(posedge clk_i) disable iff (srst_i)
        (!demod_mode && filt_sel == 2'h3 && common_ctl[irt_pkg::CM_PINSEL] && !wr_cm)
        |=> combined_output_pin_o) else $error("force high failed");

    // recovery pulse with no carrier or common control write beside it
    sequence s_stop_quiet;
        stop_recovery_i && !wr_cc && !wr_cm;
    endsequence : s_stop_quiet
    // write-one clear of the timeout flag with no new event
    sequence s_tof_clear;
        wr_cc && wdata_i[irt_pkg::CC_TOF] && !carrier_timeout_i;
    endsequence : s_tof_clear

    a_timeout_clears: assert property (@(posedge clk_i) disable iff (srst_i)
        s_tof_clear |=> !tof) else $error("timeout flag not cleared");
    // timeout beats clear in one cycle
    a_set_wins: assert property (@(posedge clk_i) disable iff (srst_i)
        (carrier_timeout_i && wr_cc && wdata_i[irt_pkg::CC_TOF]) |=> tof) else $error("clear beat timeout");
    a_stop_keeps: assert property (@(posedge clk_i) disable iff (srst_i)
        s_stop_quiet |=> carrier_ctl[6:3] == $past(carrier_ctl[6:3])) else $error("carrier fields lost");
    a_stop_logic: assert property (@(posedge clk_i) disable iff (srst_i)
        s_stop_quiet |=> edge_sel == $past(edge_sel)) else $error("logic field lost");
    a_carrier_pin: assert property (@(posedge clk_i) disable iff (srst_i)
        carrier_ctl[irt_pkg::CC_PIN] |=> carrier_output_pin_o == $past(carrier_timer_output_i))
        else $error("carrier pin not timer output");
    a_demod_pass: assert property (@(posedge clk_i) disable iff (srst_i)
        (demod_mode && filt_sel == 2'h0) |=> demod_level_o == $past(demod_raw))
        else $error("demod level not passed");
    a_fall_clears: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_cm && demod_mode && wdata_i[irt_pkg::CM_FALL] && !fall_evt) |=> !fall_flag)
        else $error("fall flag not cleared");
    a_rise_clears: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_cm && demod_mode && wdata_i[irt_pkg::CM_RISE] && !rise_evt) |=> !rise_flag)
        else $error("rise flag not cleared");
    // sync load is a single-cycle pulse
    a_sync_pulse: assert property (@(posedge clk_i) disable iff (srst_i)
        carrier_sync_load_o |=> !carrier_sync_load_o) else $error("sync load held");
endmodule : irt_regs

// file: testbench/irt_regs_tb_top.sv
// self-checking bench for the infrared timer control registers
// assumes the register block alone; every timer-side input is driven here
`timescale 1ns/100ps
module irt_regs_tb_top;
    logic       clk_i = 1'b0, srst_i = 1'b1, stop_recovery_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o;
    logic       wr_i = 1'b0, rd_i = 1'b0, carrier_timeout_i = 1'b0, carrier_capture_i = 1'b0;
    logic       carrier_timer_output_i = 1'b0, wide_timer_output_i = 1'b0, wide_start_i = 1'b0;
    logic       sync_enable_i = 1'b0, port_data_34_i = 1'b1, port_data_36_i = 1'b1;
    logic       primary_demod_input_pin_i = 1'b0, alternate_demod_input_pin_i = 1'b0;
    logic       carrier_tick_o, carrier_run_o, carrier_single_o, carrier_sync_load_o, ping_pong_o;
    logic       carrier_output_pin_o, combined_output_pin_o, demod_level_o, irq_o;
    int         error_cnt = 0;
    int         checked = 0;

    irt_regs i_dut (.clk_i, .srst_i, .stop_recovery_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .carrier_timeout_i, .carrier_capture_i, .carrier_timer_output_i, .wide_timer_output_i,
        .wide_start_i, .sync_enable_i, .port_data_34_i, .port_data_36_i, .primary_demod_input_pin_i,
        .alternate_demod_input_pin_i, .carrier_tick_o, .carrier_run_o, .carrier_single_o,
        .carrier_sync_load_o, .ping_pong_o, .carrier_output_pin_o, .combined_output_pin_o,
        .demod_level_o, .irq_o);

    always #5 clk_i = ~clk_i;

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        #1;
    endtask : wr

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // read data stand only in the cycle after the strobe
    task automatic chkrd(input string n, input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 chk(n, e, rdata_o);
    endtask : chkrd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : wait_cyc

    task automatic pulse_ev(input logic cap);
        @(posedge clk_i);
        if (cap) carrier_capture_i <= 1'b1;
        else carrier_timeout_i <= 1'b1;
        @(posedge clk_i);
        carrier_capture_i <= 1'b0;
        carrier_timeout_i <= 1'b0;
        wait_cyc(2);
    endtask : pulse_ev

    task automatic t_reset;
        for (int a = 0; a < 6; a++) chkrd("reset value", a[3:0], 8'h00);
        wr(4'h9, 8'hFF);
        chkrd("unmapped", 4'h9, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_prescale;
        int n;
        for (int p = 0; p < 4; p++) begin
            wr(4'h0, {3'h0, p[1:0], 3'h1});
            chk("running", 8'h01, {7'h0, carrier_run_o});
            n = 0;
            repeat (16) begin
                @(posedge clk_i);
                #1 n += int'(carrier_tick_o);
            end
            chk("tick count", 8'(16 >> p), 8'(n));
        end
        wr(4'h0, 8'h02);
        chk("stopped single", 8'h01, {6'h0, carrier_run_o, carrier_single_o});
        chkrd("carrier ctl", 4'h0, 8'h02);
        $display("test prescale done");
    endtask : t_prescale

    task automatic t_events;
        wr(4'h0, 8'h40);
        wr(4'h5, 8'h01);
        pulse_ev(1'b0);
        chk("irq set", 8'h01, {7'h0, irq_o});
        chkrd("timeout flag", 4'h0, 8'h44);
        wr(4'h0, 8'h00);
        chk("irq no enable", 8'h00, {7'h0, irq_o});
        chkrd("flag kept", 4'h0, 8'h04);
        wr(4'h0, 8'h40);
        wr(4'h5, 8'h00);
        chk("irq masked", 8'h00, {7'h0, irq_o});
        wr(4'h5, 8'h01);
        chk("irq unmasked", 8'h01, {7'h0, irq_o});
        wr(4'h4, 8'h01);
        chk("irq cleared", 8'h00, {7'h0, irq_o});
        // clear and new timeout on one edge: flag must stay
        @(posedge clk_i);
        addr_i  <= 4'h0;
        wdata_i <= 8'h44;
        wr_i    <= 1'b1;
        carrier_timeout_i <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
        carrier_timeout_i <= 1'b0;
        chkrd("set wins", 4'h0, 8'h44);
        wr(4'h0, 8'h44);
        chkrd("flag cleared", 4'h0, 8'h40);
        wr(4'h0, 8'h20);
        wr(4'h5, 8'h02);
        pulse_ev(1'b1);
        chk("capture irq", 8'h01, {7'h0, irq_o});
        wr(4'h4, 8'h03);
        chk("capture clr", 8'h00, {7'h0, irq_o});
        $display("test events done");
    endtask : t_events

    task automatic t_demod;
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h09);
        primary_demod_input_pin_i <= 1'b1;
        wait_cyc(6);
        primary_demod_input_pin_i <= 1'b0;
        wait_cyc(6);
        chkrd("both edges", 4'h1, 8'hC9);
        wr(4'h1, 8'h89);
        chkrd("fall cleared", 4'h1, 8'h49);
        wr(4'h1, 8'hD9);
        primary_demod_input_pin_i <= 1'b1;
        wait_cyc(2);
        primary_demod_input_pin_i <= 1'b0;
        wait_cyc(12);
        chkrd("glitch", 4'h1, 8'h19);
        chk("glitch level", 8'h00, {7'h0, demod_level_o});
        primary_demod_input_pin_i <= 1'b1;
        wait_cyc(14);
        chkrd("filtered rise", 4'h1, 8'h59);
        chk("demod level", 8'h01, {7'h0, demod_level_o});
        alternate_demod_input_pin_i <= 1'b1;
        wr(4'h1, 8'h4B);
        primary_demod_input_pin_i <= 1'b0;
        wait_cyc(6);
        chkrd("other pin", 4'h1, 8'h0B);
        alternate_demod_input_pin_i <= 1'b0;
        wait_cyc(6);
        chkrd("alt fall", 4'h1, 8'h8B);
        wr(4'h1, 8'h85);
        primary_demod_input_pin_i <= 1'b1;
        wait_cyc(6);
        primary_demod_input_pin_i <= 1'b0;
        wait_cyc(6);
        chkrd("rise only", 4'h1, 8'h45);
        wr(4'h1, 8'h41);
        primary_demod_input_pin_i <= 1'b1;
        wait_cyc(6);
        primary_demod_input_pin_i <= 1'b0;
        wait_cyc(6);
        chkrd("fall only", 4'h1, 8'h81);
        wr(4'h1, 8'h81);
        wr(4'h1, 8'h00);
        chkrd("edge status", 4'h4, 8'h04);
        $display("test demod done");
    endtask : t_demod

    task automatic t_transmit;
        logic [3:0] tt;
        wait_cyc(2);
        chk("port 34", 8'h01, {7'h0, carrier_output_pin_o});
        chk("port 36", 8'h01, {7'h0, combined_output_pin_o});
        wr(4'h0, 8'h80);
        wait_cyc(2);
        chk("timer 34", 8'h00, {7'h0, carrier_output_pin_o});
        for (int l = 0; l < 4; l++) begin
            tt = (l == 0) ? 4'h8 : (l == 1) ? 4'hE : (l == 2) ? 4'h1 : 4'h7;
            wr(4'h1, {4'h0, l[1:0], 2'h2});
            for (int v = 0; v < 4; v++) begin
                carrier_timer_output_i <= v[1];
                wide_timer_output_i    <= v[0];
                wait_cyc(3);
                chk("logic", {7'h0, tt[v]}, {7'h0, combined_output_pin_o});
            end
        end
        wr(4'h1, 8'h22);
        wait_cyc(3);
        chk("forced low", 8'h00, {7'h0, combined_output_pin_o});
        wr(4'h1, 8'h32);
        wait_cyc(3);
        chk("forced high", 8'h01, {7'h0, combined_output_pin_o});
        wr(4'h1, 8'h12);
        chk("ping pong", 8'h01, {7'h0, ping_pong_o});
        sync_enable_i <= 1'b1;
        @(posedge clk_i);
        wide_start_i <= 1'b1;
        #1 chk("sync load", 8'h01, {7'h0, carrier_sync_load_o});
        wait_cyc(1);
        chk("sync once", 8'h00, {7'h0, carrier_sync_load_o});
        $display("test transmit done");
    endtask : t_transmit

    task automatic t_stop;
        wr(4'h0, 8'h7B);
        wr(4'h1, 8'h0E);
        @(posedge clk_i);
        stop_recovery_i <= 1'b1;
        @(posedge clk_i);
        stop_recovery_i <= 1'b0;
        chkrd("ctl kept", 4'h0, 8'h78);
        chkrd("logic kept", 4'h1, 8'h0C);
        $display("test stop recovery done");
    endtask : t_stop

    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    initial begin
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        t_reset;
        t_prescale;
        t_events;
        t_demod;
        t_transmit;
        t_stop;
        conclude;
    end

    // whole run is a few hundred cycles
    initial begin
        #200000;
        error_cnt++;
        $display("watchdog expired");
        conclude;
    end
endmodule : irt_regs_tb_top
